//--- include/gfc_defines.svh
// Purpose: Constants of the gated frequency counter control block
// Assumes: 20 MHz system clock, 32-bit AXI4-Lite register bus
// Notes:   Offsets are byte addresses of aligned words
//
// Contract
// - No measurement starts without an arm command
// - Armed gate opens on next input edge
// - Gate closes on first edge after gate time
// - Low variant divides channel B by four
// - High variant divides channel B by 256
// - Interpolator measures gate-to-reference edge offsets
// - Interpolator clear input resets interpolator counters
// - External reference, at most 5 MHz, may replace internal
`ifndef GFC_DEFINES_SVH
`define GFC_DEFINES_SVH

// Register offsets
`define GFC_OFS_CTRL      8'h00
`define GFC_OFS_GATE      8'h04
`define GFC_OFS_STATUS    8'h08
`define GFC_OFS_EVENTS    8'h0c
`define GFC_OFS_REFS      8'h10
`define GFC_OFS_IP_START  8'h14
`define GFC_OFS_IP_STOP   8'h18
`define GFC_OFS_INT_STAT  8'h1c
`define GFC_OFS_INT_MASK  8'h20
`define GFC_ADDR_W        8

// Control fields
`define GFC_CTRL_CHAN_B   0
`define GFC_CTRL_DIV256   1
`define GFC_CTRL_EXT_REF  2
`define GFC_CTRL_ARM      8
`define GFC_CTRL_IP_CLR   9

// Status and interrupt fields
`define GFC_ST_BUSY       0
`define GFC_ST_DONE       1
`define GFC_INT_OPENED    0
`define GFC_INT_DONE      1
`define GFC_INT_REFUSED   2
`define GFC_INT_W         3

// Reset values
`define GFC_GATE_RST      32'h000f4240
`define GFC_CTRL_RST      3'h0
`define GFC_MASK_RST      3'h0

// Prescaler terminal counts
`define GFC_DIV_LO_TC     8'h03
`define GFC_DIV_HI_TC     8'hff

// Timing
`define GFC_CLK_HZ        20000000
`define GFC_REF_HZ        10000000
`define GFC_REF_DIV_CYC   (`GFC_CLK_HZ / `GFC_REF_HZ)
`define GFC_REF_TC        1'((`GFC_REF_DIV_CYC) - 1)

// Bus responses
`define GFC_RESP_OKAY     2'h0
`define GFC_RESP_SLVERR   2'h2

`endif

//--- include/gfc_pkg.sv
// Purpose: Types of the gated frequency counter control block
// Assumes: Used with gfc_defines.svh
// Notes:   Nothing here is imported; users write gfc_pkg::name
package gfc_pkg;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ARMED,
    ST_OPEN,
    ST_DONE
  } gfc_state_t;

  typedef struct packed {
    logic [31:0] events;
    logic [31:0] refs;
    logic [15:0] ip_start;
    logic [15:0] ip_stop;
  } gfc_result_t;

  typedef struct packed {
    logic chan_b;
    logic div256;
    logic ext_ref;
  } gfc_cfg_t;

endpackage : gfc_pkg

//--- design/gfc_sync.sv
// Purpose: Three-stage input synchroniser with rising-edge pulse
// Assumes: Input is asynchronous to CLK
// Notes:   A level counts once the second and third stages agree
`timescale 1ns/100ps
module gfc_sync (
  // Clock and reset
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  // Pin and result
  input  wire logic pin_in,
  output logic      rise_out
);

  logic ff1_q;
  logic ff2_q;
  logic ff3_q;
  logic lvl_q;
  wire  agree = (ff2_q == ff3_q);

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ff1_q <= 1'b0;
      ff2_q <= 1'b0;
      ff3_q <= 1'b0;
      lvl_q <= 1'b0;
    end else begin
      ff1_q <= pin_in;
      ff2_q <= ff1_q;
      ff3_q <= ff2_q;
      if (agree) begin
        lvl_q <= ff3_q;
      end
    end
  end

  assign rise_out = agree & ff3_q & ~lvl_q;

endmodule : gfc_sync

//--- design/gfc_prescaler.sv
// Purpose: Fixed channel B prescaler, divide by 4 or by 256
// Assumes: Input is a one-cycle edge pulse
// Notes:   Ratio is chosen by the variant bit; changing it mid-run
//          may shorten one output period
`timescale 1ns/100ps
`include "gfc_defines.svh"
module gfc_prescaler (
  // Clock and reset
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  // Control
  input  wire logic div256_in,
  // Pulses
  input  wire logic edge_in,
  output logic      pulse_out
);

  logic [7:0] cnt_q;
  logic [7:0] cnt_d;
  logic       pulse_d;
  wire  [7:0] tc = div256_in ? `GFC_DIV_HI_TC
                             : `GFC_DIV_LO_TC;
  wire        wrap = edge_in & (cnt_q >= tc);

  assign cnt_d   = wrap ? 8'h00 : (edge_in ? cnt_q + 8'h01 : cnt_q);
  assign pulse_d = wrap;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_q     <= 8'h00;
      pulse_out <= 1'b0;
    end else begin
      cnt_q     <= cnt_d;
      pulse_out <= pulse_d;
    end
  end

endmodule : gfc_prescaler

//--- design/gfc_counter_ctrl.sv
// Purpose: Measurement gate, event and reference counting, interpolator
// Assumes: AXI4-Lite slave, one write and one read at a time
// Notes:   Results stay frozen until software reads the event count;
//          display refresh pacing is left to software
`timescale 1ns/100ps
`include "gfc_defines.svh"
module gfc_counter_ctrl (
  // Clock and reset
  input  wire logic        CLK_IN,
  input  wire logic        RESET_N_IN,
  // Write address channel
  input  wire logic        AXI_AWVALID_IN,
  input  wire logic [7:0]  AXI_AWADDR_IN,
  output logic             AXI_AWREADY_OUT,
  // Write data channel
  input  wire logic        AXI_WVALID_IN,
  input  wire logic [31:0] AXI_WDATA_IN,
  input  wire logic [3:0]  AXI_WSTRB_IN,
  output logic             AXI_WREADY_OUT,
  // Write response channel
  input  wire logic        AXI_BREADY_IN,
  output logic             AXI_BVALID_OUT,
  output logic [1:0]       AXI_BRESP_OUT,
  // Read address channel
  input  wire logic        AXI_ARVALID_IN,
  input  wire logic [7:0]  AXI_ARADDR_IN,
  output logic             AXI_ARREADY_OUT,
  // Read data channel
  input  wire logic        AXI_RREADY_IN,
  output logic             AXI_RVALID_OUT,
  output logic [31:0]      AXI_RDATA_OUT,
  output logic [1:0]       AXI_RRESP_OUT,
  // Signal inputs
  input  wire logic        CHAN_A_IN,
  input  wire logic        CHAN_B_IN,
  input  wire logic        EXT_REF_IN,
  // Status outputs
  output logic             GATE_OPEN_OUT,
  output logic             IRQ_OUT
);

  // Synchronised pins: A, B, external reference
  logic [2:0] pins;
  logic [2:0] rises;
  logic       chan_b_div;

  assign pins = {EXT_REF_IN, CHAN_B_IN, CHAN_A_IN};

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_sync
      gfc_sync u_sync (
        .clk_in   (CLK_IN),
        .rst_n_in (RESET_N_IN),
        .pin_in   (pins[gi]),
        .rise_out (rises[gi])
      );
    end
  endgenerate

  // Configuration and control state
  gfc_pkg::gfc_cfg_t    cfg_q;
  gfc_pkg::gfc_cfg_t    cfg_d;
  gfc_pkg::gfc_state_t  state_q;
  gfc_pkg::gfc_state_t  state_d;
  gfc_pkg::gfc_result_t res_q;
  gfc_pkg::gfc_result_t res_d;
  logic [31:0]          gate_q;
  logic [31:0]          gate_d;
  logic                 ip_start_run_q;
  logic                 ip_start_run_d;
  logic                 ip_stop_run_q;
  logic                 ip_stop_run_d;
  logic                 ref_div_q;
  logic                 ref_div_d;
  logic [`GFC_INT_W-1:0] int_stat_q;
  logic [`GFC_INT_W-1:0] int_stat_d;
  logic [`GFC_INT_W-1:0] int_mask_q;
  logic [`GFC_INT_W-1:0] int_mask_d;

  gfc_prescaler u_presc (
    .clk_in    (CLK_IN),
    .rst_n_in  (RESET_N_IN),
    .div256_in (cfg_q.div256),
    .edge_in   (rises[1]),
    .pulse_out (chan_b_div)
  );

  // Bus slave state
  logic                  aw_hold_q;
  logic                  aw_hold_d;
  logic [`GFC_ADDR_W-1:0] awaddr_q;
  logic                  w_hold_q;
  logic                  w_hold_d;
  logic [31:0]           wdata_q;
  logic [3:0]            wstrb_q;
  logic                  bvalid_d;
  logic                  awready_d;
  logic                  wready_d;
  logic                  rvalid_d;
  logic                  arready_d;
  logic [31:0]           rdata_d;
  logic [1:0]            rresp_d;
  logic [1:0]            bresp_d;

  wire aw_take = AXI_AWVALID_IN & AXI_AWREADY_OUT;
  wire w_take  = AXI_WVALID_IN & AXI_WREADY_OUT;
  wire wr_fire = aw_hold_q & w_hold_q;
  wire ar_take = AXI_ARVALID_IN & AXI_ARREADY_OUT;

  assign aw_hold_d = (aw_hold_q | aw_take) & ~wr_fire;
  assign w_hold_d  = (w_hold_q | w_take) & ~wr_fire;
  assign bvalid_d  = wr_fire | (AXI_BVALID_OUT & ~AXI_BREADY_IN);
  assign awready_d = ~aw_hold_d & ~bvalid_d;
  assign wready_d  = ~w_hold_d & ~bvalid_d;
  assign rvalid_d  = ar_take | (AXI_RVALID_OUT & ~AXI_RREADY_IN);
  assign arready_d = ~rvalid_d;

  // Write decode
  wire wr_ctrl  = wr_fire & (awaddr_q == `GFC_OFS_CTRL);
  wire wr_gate  = wr_fire & (awaddr_q == `GFC_OFS_GATE);
  wire wr_mask  = wr_fire & (awaddr_q == `GFC_OFS_INT_MASK);
  wire wr_known = wr_ctrl | wr_gate | wr_mask |
                  (awaddr_q == `GFC_OFS_STATUS)   |
                  (awaddr_q == `GFC_OFS_EVENTS)   |
                  (awaddr_q == `GFC_OFS_REFS)     |
                  (awaddr_q == `GFC_OFS_IP_START) |
                  (awaddr_q == `GFC_OFS_IP_STOP)  |
                  (awaddr_q == `GFC_OFS_INT_STAT);
  assign bresp_d = wr_fire ? (wr_known ? `GFC_RESP_OKAY : `GFC_RESP_SLVERR)
                           : AXI_BRESP_OUT;

  // Arm and interpolator clear are write-one pulses in byte lane 1
  wire arm_req = wr_ctrl & wstrb_q[1] & wdata_q[`GFC_CTRL_ARM];
  wire ip_clr  = wr_ctrl & wstrb_q[1] & wdata_q[`GFC_CTRL_IP_CLR];
  wire arm_ok  = arm_req & (state_q == gfc_pkg::ST_IDLE);
  wire arm_bad = arm_req & ~arm_ok;

  // Byte-lane merge for word registers
  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  // Configuration may change only while idle, so a run keeps its mode
  wire cfg_wr = wr_ctrl & wstrb_q[0] & (state_q == gfc_pkg::ST_IDLE);
  assign cfg_d.chan_b  = cfg_wr ? wdata_q[`GFC_CTRL_CHAN_B]
                                : cfg_q.chan_b;
  assign cfg_d.div256  = cfg_wr ? wdata_q[`GFC_CTRL_DIV256]
                                : cfg_q.div256;
  assign cfg_d.ext_ref = cfg_wr ? wdata_q[`GFC_CTRL_EXT_REF]
                                : cfg_q.ext_ref;
  assign gate_d = (wr_gate & (state_q == gfc_pkg::ST_IDLE))
                ? merge(gate_q, wdata_q, wstrb_q) : gate_q;
  assign int_mask_d = wr_mask & wstrb_q[0]
                    ? wdata_q[`GFC_INT_W-1:0] : int_mask_q;

  // Reference tick: internal divider or synchronised external edge
  assign ref_div_d = (ref_div_q == `GFC_REF_TC) ? 1'b0
                                                : ref_div_q + 1'b1;
  wire int_tick = (ref_div_q == `GFC_REF_TC);
  wire ref_tick = cfg_q.ext_ref ? rises[2] : int_tick;

  // Input under measurement
  wire sig_edge = cfg_q.chan_b ? chan_b_div : rises[0];

  // Gate control
  wire elapsed   = (res_q.refs >= gate_q);
  wire do_open   = (state_q == gfc_pkg::ST_ARMED) & sig_edge;
  wire do_close  = (state_q == gfc_pkg::ST_OPEN) & elapsed &
                   sig_edge;
  wire rd_events = ar_take & (AXI_ARADDR_IN == `GFC_OFS_EVENTS);
  wire rd_istat  = ar_take & (AXI_ARADDR_IN == `GFC_OFS_INT_STAT);

  always_comb begin
    state_d = state_q;
    case (state_q)
      gfc_pkg::ST_IDLE: begin
        if (arm_ok) begin
          state_d = gfc_pkg::ST_ARMED;
        end
      end
      gfc_pkg::ST_ARMED: begin
        if (do_open) begin
          state_d = gfc_pkg::ST_OPEN;
        end
      end
      gfc_pkg::ST_OPEN: begin
        if (do_close) begin
          state_d = gfc_pkg::ST_DONE;
        end
      end
      gfc_pkg::ST_DONE: begin
        if (rd_events) begin
          state_d = gfc_pkg::ST_IDLE;
        end
      end
      default: begin
        state_d = gfc_pkg::ST_IDLE;
      end
    endcase
  end

  // Counters: the closing edge is counted, the opening one is not,
  // so a gate of n input periods holds exactly n events
  wire in_gate = (state_q == gfc_pkg::ST_OPEN);
  assign res_d.events = do_open ? 32'h0000_0000
                      : (in_gate & sig_edge) ? res_q.events + 32'h0000_0001
                      : res_q.events;
  assign res_d.refs   = do_open ? 32'h0000_0000
                      : (in_gate & ref_tick) ? res_q.refs + 32'h0000_0001
                      : res_q.refs;

  // Interpolator: cycles from each gate edge to the next reference tick
  assign ip_start_run_d = ip_clr ? 1'b0
                        : do_open ? ~ref_tick
                        : ip_start_run_q & ~ref_tick;
  assign ip_stop_run_d  = ip_clr ? 1'b0
                        : do_close ? ~ref_tick
                        : ip_stop_run_q & ~ref_tick;
  assign res_d.ip_start = (ip_clr | do_open) ? 16'h0000
                        : ip_start_run_q ? res_q.ip_start + 16'h0001
                        : res_q.ip_start;
  assign res_d.ip_stop  = (ip_clr | do_close) ? 16'h0000
                        : ip_stop_run_q ? res_q.ip_stop + 16'h0001
                        : res_q.ip_stop;

  // Sticky interrupt status: a read clears, a new event in the same
  // cycle still wins
  wire [`GFC_INT_W-1:0] int_evt;
  assign int_evt[`GFC_INT_OPENED]  = do_open;
  assign int_evt[`GFC_INT_DONE]    = do_close;
  assign int_evt[`GFC_INT_REFUSED] = arm_bad;
  assign int_stat_d = (rd_istat ? {`GFC_INT_W{1'b0}} : int_stat_q) |
                      int_evt;
  wire irq_d = |(int_stat_d & int_mask_d);

  // Read mux
  wire [31:0] status_word = {30'h0000_0000,
                             state_q == gfc_pkg::ST_DONE,
                             state_q != gfc_pkg::ST_IDLE};
  wire [31:0] ctrl_word   = {29'h0000_0000, cfg_q.ext_ref,
                             cfg_q.div256, cfg_q.chan_b};

  always_comb begin
    rdata_d = 32'h0000_0000;
    rresp_d = `GFC_RESP_OKAY;
    case (AXI_ARADDR_IN)
      `GFC_OFS_CTRL:     rdata_d = ctrl_word;
      `GFC_OFS_GATE:     rdata_d = gate_q;
      `GFC_OFS_STATUS:   rdata_d = status_word;
      `GFC_OFS_EVENTS:   rdata_d = res_q.events;
      `GFC_OFS_REFS:     rdata_d = res_q.refs;
      `GFC_OFS_IP_START: rdata_d = {16'h0000, res_q.ip_start};
      `GFC_OFS_IP_STOP:  rdata_d = {16'h0000, res_q.ip_stop};
      `GFC_OFS_INT_STAT: rdata_d = {29'h0000_0000, int_stat_q};
      `GFC_OFS_INT_MASK: rdata_d = {29'h0000_0000, int_mask_q};
      default:           rresp_d = `GFC_RESP_SLVERR;
    endcase
  end

  // Bus slave registers
  always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      aw_hold_q       <= 1'b0;
      w_hold_q        <= 1'b0;
      awaddr_q        <= 8'h00;
      wdata_q         <= 32'h0000_0000;
      wstrb_q         <= 4'h0;
      AXI_AWREADY_OUT <= 1'b0;
      AXI_WREADY_OUT  <= 1'b0;
      AXI_BVALID_OUT  <= 1'b0;
      AXI_BRESP_OUT   <= `GFC_RESP_OKAY;
      AXI_ARREADY_OUT <= 1'b0;
      AXI_RVALID_OUT  <= 1'b0;
    end else begin
      aw_hold_q       <= aw_hold_d;
      w_hold_q        <= w_hold_d;
      AXI_AWREADY_OUT <= awready_d;
      AXI_WREADY_OUT  <= wready_d;
      AXI_BVALID_OUT  <= bvalid_d;
      AXI_BRESP_OUT   <= bresp_d;
      AXI_ARREADY_OUT <= arready_d;
      AXI_RVALID_OUT  <= rvalid_d;
      if (aw_take) begin
        awaddr_q <= AXI_AWADDR_IN;
      end
      if (w_take) begin
        wdata_q <= AXI_WDATA_IN;
        wstrb_q <= AXI_WSTRB_IN;
      end
    end
  end

  always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      AXI_RDATA_OUT <= 32'h0000_0000;
      AXI_RRESP_OUT <= `GFC_RESP_OKAY;
    end else if (ar_take) begin
      AXI_RDATA_OUT <= rdata_d;
      AXI_RRESP_OUT <= rresp_d;
    end
  end

  // Block state registers
  always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      cfg_q          <= `GFC_CTRL_RST;
      gate_q         <= `GFC_GATE_RST;
      int_mask_q     <= `GFC_MASK_RST;
      int_stat_q     <= {`GFC_INT_W{1'b0}};
      state_q        <= gfc_pkg::ST_IDLE;
      res_q          <= '0;
      ip_start_run_q <= 1'b0;
      ip_stop_run_q  <= 1'b0;
      ref_div_q      <= 1'b0;
      GATE_OPEN_OUT  <= 1'b0;
      IRQ_OUT        <= 1'b0;
    end else begin
      cfg_q          <= cfg_d;
      gate_q         <= gate_d;
      int_mask_q     <= int_mask_d;
      int_stat_q     <= int_stat_d;
      state_q        <= state_d;
      res_q          <= res_d;
      ip_start_run_q <= ip_start_run_d;
      ip_stop_run_q  <= ip_stop_run_d;
      ref_div_q      <= ref_div_d;
      GATE_OPEN_OUT  <= (state_d == gfc_pkg::ST_OPEN);
      IRQ_OUT        <= irq_d;
    end
  end

endmodule : gfc_counter_ctrl

//--- dv/gfc_counter_ctrl_assertions.sv
// Purpose: Port checks of the counter control block
// Assumes: One clock domain, asynchronous active-low reset
// Notes:   Edge bounds allow for synchroniser and prescaler delay
`timescale 1ns/100ps
module gfc_chk (
  // Clock and reset
  input wire logic CLK_IN,
  input wire logic RESET_N_IN,
  // Register bus
  input wire logic AXI_AWVALID_IN,
  input wire logic AXI_AWREADY_OUT,
  input wire logic AXI_WVALID_IN,
  input wire logic [31:0] AXI_WDATA_IN,
  input wire logic [3:0] AXI_WSTRB_IN,
  input wire logic AXI_WREADY_OUT,
  input wire logic AXI_BREADY_IN,
  input wire logic AXI_BVALID_OUT,
  input wire logic AXI_ARVALID_IN,
  input wire logic AXI_ARREADY_OUT,
  input wire logic AXI_RREADY_IN,
  input wire logic AXI_RVALID_OUT,
  // Signals
  input wire logic CHAN_A_IN,
  input wire logic CHAN_B_IN,
  input wire logic GATE_OPEN_OUT
);
  logic       a_q;
  logic       b_q;
  logic       wr_seen_q;
  logic [7:0] since_q;
  logic [7:0] since_d;
  wire        edge_seen = (CHAN_A_IN & ~a_q) | (CHAN_B_IN & ~b_q);
  // Only a write carrying the arm pulse in lane 1 counts as an arm
  wire        arm_take = AXI_WVALID_IN & AXI_WREADY_OUT &
                         AXI_WSTRB_IN[1] & AXI_WDATA_IN[8];
  // Saturates so a long quiet spell never wraps to a small value
  assign since_d = edge_seen ? 8'h00 :
                   (since_q == 8'hff) ? since_q : since_q + 8'h01;
  always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      a_q       <= 1'b0;
      b_q       <= 1'b0;
      since_q   <= 8'hff;
      wr_seen_q <= 1'b0;
    end else begin
      a_q       <= CHAN_A_IN;
      b_q       <= CHAN_B_IN;
      since_q   <= since_d;
      wr_seen_q <= GATE_OPEN_OUT ? 1'b0 : (wr_seen_q | arm_take);
    end
  end
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!RESET_N_IN);
  sequence s_wr_take;
    AXI_AWVALID_IN && AXI_AWREADY_OUT && AXI_WVALID_IN && AXI_WREADY_OUT;
  endsequence
  sequence s_rd_take;
    AXI_ARVALID_IN && AXI_ARREADY_OUT;
  endsequence
  a_write_answer: assert property (s_wr_take |-> ##[1:3] AXI_BVALID_OUT)
    else $error("write response late");
  a_read_answer: assert property (s_rd_take |-> ##[1:2] AXI_RVALID_OUT)
    else $error("read data late");
  a_b_release: assert property (AXI_BVALID_OUT && AXI_BREADY_IN
    |=> !AXI_BVALID_OUT) else $error("write response not released");
  a_r_release: assert property (AXI_RVALID_OUT && AXI_RREADY_IN
    |=> !AXI_RVALID_OUT) else $error("read data not released");
  a_aw_blocked: assert property (AXI_BVALID_OUT
    |-> !AXI_AWREADY_OUT && !AXI_WREADY_OUT) else $error("write reopened");
  a_ar_blocked: assert property (AXI_RVALID_OUT |-> !AXI_ARREADY_OUT)
    else $error("read reopened");
  a_arm_first: assert property ($rose(GATE_OPEN_OUT) |-> wr_seen_q)
    else $error("gate opened without arm");
  a_open_on_edge: assert property ($rose(GATE_OPEN_OUT)
    |-> since_q <= 8'h0a) else $error("gate opened off an edge");
  a_close_on_edge: assert property ($fell(GATE_OPEN_OUT)
    |-> since_q <= 8'h0a) else $error("gate closed off an edge");
endmodule : gfc_chk
bind gfc_counter_ctrl gfc_chk u_gfc_chk (
  .CLK_IN(CLK_IN), .RESET_N_IN(RESET_N_IN),
  .AXI_AWVALID_IN(AXI_AWVALID_IN), .AXI_AWREADY_OUT(AXI_AWREADY_OUT),
  .AXI_WVALID_IN(AXI_WVALID_IN), .AXI_WREADY_OUT(AXI_WREADY_OUT),
  .AXI_WDATA_IN(AXI_WDATA_IN), .AXI_WSTRB_IN(AXI_WSTRB_IN),
  .AXI_BREADY_IN(AXI_BREADY_IN), .AXI_BVALID_OUT(AXI_BVALID_OUT),
  .AXI_ARVALID_IN(AXI_ARVALID_IN), .AXI_ARREADY_OUT(AXI_ARREADY_OUT),
  .AXI_RREADY_IN(AXI_RREADY_IN), .AXI_RVALID_OUT(AXI_RVALID_OUT),
  .CHAN_A_IN(CHAN_A_IN), .CHAN_B_IN(CHAN_B_IN),
  .GATE_OPEN_OUT(GATE_OPEN_OUT));

//--- dv/gfc_sig_src.sv
// Purpose: Conditioned channel signals and external reference
// Assumes: Half periods in ns; edges never land on a rising clock edge
// Notes:   A stopped source rests low, like an idle shaped input
`timescale 1ns/100ps
module gfc_sig_src (
  // Controls
  input  wire logic        run_a_in,
  input  wire logic        run_b_in,
  input  wire logic        run_ref_in,
  input  wire logic [15:0] half_a_in,
  input  wire logic [15:0] half_b_in,
  // Signals
  output logic             chan_a_out,
  output logic             chan_b_out,
  output logic             ref_out
);
  initial chan_a_out = 1'b0;
  initial chan_b_out = 1'b0;
  initial ref_out = 1'b0;
  always begin
    #(half_a_in);
    chan_a_out = run_a_in ? ~chan_a_out : 1'b0;
  end
  always begin
    #(half_b_in);
    chan_b_out = run_b_in ? ~chan_b_out : 1'b0;
  end
  // Reference runs at 5 MHz: the three-stage filter needs each level
  // to last two clock cycles, so 10 MHz cannot pass a 20 MHz clock
  always begin
    #100;
    ref_out = run_ref_in ? ~ref_out : 1'b0;
  end
endmodule : gfc_sig_src

//--- dv/tb_gfc_counter_ctrl.sv
// Purpose: Self-checking bench of the counter control block
// Assumes: 20 MHz clock; gate time 20 reference ticks (2 us internal, 4 us external)
// Notes:   Ref counts are checked in a band, as gate edges are async
`timescale 1ns/100ps
`include "gfc_defines.svh"
module tb_gfc_counter_ctrl;
  logic        clk = 1'b0, rst_n = 1'b0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, rd_v;
  logic [3:0]  wstrb = 4'h0;
  logic [1:0]  bresp, rresp, rd_r;
  logic        awready, wready, bvalid, arready, rvalid, gate, irq;
  logic        chan_a, chan_b, ext_ref;
  logic        run_a = 1'b0, run_b = 1'b0, run_ref = 1'b0;
  int          err_count = 0, n_checks = 0, cycles = 0;
  always #25 clk = ~clk;
  gfc_counter_ctrl u_gfc_counter_ctrl (.CLK_IN(clk), .RESET_N_IN(rst_n),
    .AXI_AWVALID_IN(awvalid), .AXI_AWADDR_IN(awaddr),
    .AXI_AWREADY_OUT(awready), .AXI_WVALID_IN(wvalid),
    .AXI_WDATA_IN(wdata), .AXI_WSTRB_IN(wstrb), .AXI_WREADY_OUT(wready),
    .AXI_BREADY_IN(bready), .AXI_BVALID_OUT(bvalid), .AXI_BRESP_OUT(bresp),
    .AXI_ARVALID_IN(arvalid), .AXI_ARADDR_IN(araddr),
    .AXI_ARREADY_OUT(arready), .AXI_RREADY_IN(rready),
    .AXI_RVALID_OUT(rvalid), .AXI_RDATA_OUT(rdata), .AXI_RRESP_OUT(rresp),
    .CHAN_A_IN(chan_a), .CHAN_B_IN(chan_b), .EXT_REF_IN(ext_ref),
    .GATE_OPEN_OUT(gate), .IRQ_OUT(irq));
  gfc_sig_src u_gfc_sig_src (.run_a_in(run_a), .run_b_in(run_b),
    .run_ref_in(run_ref), .half_a_in(16'd230), .half_b_in(16'd110),
    .chan_a_out(chan_a), .chan_b_out(chan_b), .ref_out(ext_ref));
  task automatic close_out();
    $display("TB: errors %0d checks %0d", err_count, n_checks);
    if (err_count == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : close_out
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t: word %h expected %h", $time, got, exp);
    end
  endtask : chk_word
  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t: response %h expected %h", $time, got, exp);
    end
  endtask : chk_resp
  task automatic chk_bit(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t: flag %b expected %b", $time, got, exp);
    end
  endtask : chk_bit
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                        input logic [3:0] s, input logic [1:0] e);
    @(posedge clk);
    awvalid <= 1'b1;
    awaddr  <= a;
    wvalid  <= 1'b1;
    wdata   <= d;
    wstrb   <= s;
    bready  <= 1'b1;
    do begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!(bvalid && bready));
    bready <= 1'b0;
    chk_resp(bresp, e);
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a);
    @(posedge clk);
    arvalid <= 1'b1;
    araddr  <= a;
    rready  <= 1'b1;
    do begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!(rvalid && rready));
    rready <= 1'b0;
    rd_v = rdata;
    rd_r = rresp;
  endtask : axi_rd
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    axi_rd(a);
    chk_word(rd_v, e);
    chk_resp(rd_r, `GFC_RESP_OKAY);
  endtask : rd_chk
  task automatic arm(input logic [31:0] cfg);
    axi_wr(`GFC_OFS_CTRL, cfg, 4'h1, `GFC_RESP_OKAY);
    rd_chk(`GFC_OFS_CTRL, cfg);
    axi_wr(`GFC_OFS_CTRL, 32'h100, 4'h2, `GFC_RESP_OKAY);
  endtask : arm
  // A zero event count skips the interpolator and event checks
  // One result fetch per run, far above four refreshes a second
  task automatic finish(input logic [31:0] ev, lo, hi);
    while (gate !== 1'b1) @(posedge clk);
    repeat (2) @(posedge clk);
    chk_bit(irq, 1'b0);
    while (gate !== 1'b0) @(posedge clk);
    repeat (4) @(posedge clk);
    chk_bit(irq, 1'b1);
    rd_chk(`GFC_OFS_STATUS, 32'h3);
    axi_wr(`GFC_OFS_CTRL, 32'h100, 4'h2, `GFC_RESP_OKAY);
    rd_chk(`GFC_OFS_STATUS, 32'h3);
    rd_chk(`GFC_OFS_INT_STAT, 32'h7);
    repeat (3) @(posedge clk);
    chk_bit(irq, 1'b0);
    axi_rd(`GFC_OFS_REFS);
    chk_bit(rd_v >= lo && rd_v <= hi, 1'b1);
    if (ev != 32'h0) begin
      axi_rd(`GFC_OFS_IP_START);
      chk_bit(rd_v <= 32'h2, 1'b1);
      axi_wr(`GFC_OFS_CTRL, 32'h200, 4'h2, `GFC_RESP_OKAY);
      rd_chk(`GFC_OFS_IP_START, 32'h0);
      rd_chk(`GFC_OFS_IP_STOP, 32'h0);
      rd_chk(`GFC_OFS_EVENTS, ev);
    end else begin
      axi_rd(`GFC_OFS_EVENTS);
    end
    rd_chk(`GFC_OFS_STATUS, 32'h0);
  endtask : finish
  // Hang guard, well above the whole bench of about 3000 cycles, counted from time zero
  always @(posedge clk) begin
    cycles++;
    if (cycles == 8000) begin
      err_count++;
      $display("ERROR %0t: timeout", $time);
      close_out();
    end
  end
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    rd_chk(`GFC_OFS_GATE, `GFC_GATE_RST);
    rd_chk(`GFC_OFS_CTRL, 32'h0);
    rd_chk(`GFC_OFS_STATUS, 32'h0);
    rd_chk(`GFC_OFS_INT_MASK, 32'h0);
    axi_rd(8'h40);
    chk_resp(rd_r, `GFC_RESP_SLVERR);
    axi_wr(8'h40, 32'h1, 4'hf, `GFC_RESP_SLVERR);
    axi_wr(`GFC_OFS_GATE, 32'd20, 4'hf, `GFC_RESP_OKAY);
    axi_wr(`GFC_OFS_INT_MASK, 32'h2, 4'h1, `GFC_RESP_OKAY);
    rd_chk(`GFC_OFS_INT_MASK, 32'h2);
    arm(32'h0);
    repeat (20) @(posedge clk);
    chk_bit(gate, 1'b0);
    rd_chk(`GFC_OFS_STATUS, 32'h1);
    axi_wr(`GFC_OFS_CTRL, 32'h100, 4'h2, `GFC_RESP_OKAY);
    axi_wr(`GFC_OFS_GATE, 32'd5, 4'hf, `GFC_RESP_OKAY);
    rd_chk(`GFC_OFS_GATE, 32'd20);
    rd_chk(`GFC_OFS_INT_STAT, 32'h4);
    run_a <= 1'b1;
    finish(32'd5, 32'd22, 32'd24);
    run_b <= 1'b1;
    arm(32'h1);
    finish(32'd3, 32'd25, 32'd27);
    arm(32'h3);
    finish(32'd1, 32'd562, 32'd564);
    run_b <= 1'b0;
    arm(32'h4);
    while (gate !== 1'b1) @(posedge clk);
    repeat (100) @(posedge clk);
    chk_bit(gate, 1'b1);
    run_ref <= 1'b1;
    finish(32'h0, 32'd20, 32'd25);
    close_out();
  end
endmodule : tb_gfc_counter_ctrl
